//--- common/asc_map.svh
// register offsets, field positions, reset values for the step config bank
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_STEP5_IDX 8'h95
`define ASC_STEP6_IDX 8'h96
`define ASC_STEP5_ADDR 12'h254
`define ASC_STEP6_ADDR 12'h258
`define ASC_STEP5_RST 16'h0005
`define ASC_STEP6_RST 16'h0006
`define ASC_EN_BIT 15
`define ASC_GAIN_HI 14
`define ASC_GAIN_LO 13
`define ASC_RSV_HI 12
`define ASC_RSV_LO 5
`define ASC_NEG_BIT 4
`define ASC_POS_HI 3
`define ASC_POS_LO 0
`define ASC_WMASK 16'he01f
`endif

//--- common/asc_pkg.sv
// types for the auxiliary converter step configuration bank
package asc_pkg;
	typedef enum logic [1:0] {
		ASC_GAIN_X1 = 2'h0,
		ASC_GAIN_X2 = 2'h1,
		ASC_GAIN_X4 = 2'h2
	} asc_gain_t;
	typedef enum logic [3:0] {
		ASC_NEG_GND = 4'h1,
		ASC_NEG_EXT7 = 4'h2,
		ASC_NEG_AUTO = 4'h4
	} asc_neg_t;
	// one-hot source kinds: external pin, internal source
	typedef enum logic [1:0] {
		ASC_SRC_EXT = 2'h1,
		ASC_SRC_INT = 2'h2
	} asc_src_t;
endpackage

//--- hw/asc_step_reg.sv
// one sixteen-bit step configuration register with fixed-zero reserved bits
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_step_reg #(
	parameter logic [15:0] RST_VAL = 16'h0000
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic wr_en, // one-cycle write strobe
	input wire logic [15:0] wr_data, // write data
	output logic [15:0] q // stored value
);
	logic [15:0] q_ff;
	logic [15:0] nxt_q;

	always_comb begin
		nxt_q = q_ff;
		if (wr_en) begin
			// reserved field never stores anything
			nxt_q = wr_data & `ASC_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff <= RST_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule // asc_step_reg

//--- hw/asc_step_decode.sv
// decodes a step configuration word into converter steering controls
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_step_decode (
	input wire logic [15:0] cfg, // configuration word
	output logic enable, // step included in sequence
	output asc_pkg::asc_gain_t gain, // decoded gain
	output asc_pkg::asc_neg_t neg_sel, // negative input route
	output logic [3:0] pos_sel, // positive input code
	output asc_pkg::asc_src_t src_kind // external or internal
);
	logic [1:0] g;
	logic [3:0] p;

	always_comb begin
		g = cfg[`ASC_GAIN_HI:`ASC_GAIN_LO];
		p = cfg[`ASC_POS_HI:`ASC_POS_LO];
		enable = cfg[`ASC_EN_BIT];
		pos_sel = p;
		unique case (g)
			2'h0: gain = asc_pkg::ASC_GAIN_X1;
			2'h1: gain = asc_pkg::ASC_GAIN_X2;
			default: gain = asc_pkg::ASC_GAIN_X4;
		endcase
		if (p[3]) begin
			// internal sources pick their own return path
			neg_sel = asc_pkg::ASC_NEG_AUTO;
			src_kind = asc_pkg::ASC_SRC_INT;
		end else begin
			src_kind = asc_pkg::ASC_SRC_EXT;
			if (cfg[`ASC_NEG_BIT]) begin
				neg_sel = asc_pkg::ASC_NEG_EXT7;
			end else begin
				neg_sel = asc_pkg::ASC_NEG_GND;
			end
		end
	end
endmodule // asc_step_decode

//--- hw/asc_step_cfg.sv
// APB register bank for the auxiliary converter sequence steps 5 and 6
//
// Behaviour
// - bit 15 includes the step in the sequence when set, skips when clear
// - gain bits 14:13: 00 gain 1, 01 gain 2, 10 and 11 gain 4
// - bits 12:5 read as zero whatever is written
// - bit 4 picks negative input: 0 ground, 1 external input seven
// - positive codes 0..7 route external inputs zero..seven
// - codes 8,9,10: temperature sensor, internal ground short, test dac
// - code 11 analog supply/4; 14,15 analog/digital power input /103
// - positive codes 8 and above choose negative input automatically
// - step 6 register at 96h, resets to 0006h
// - step 5 register at 95h, resets to 0005h
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_step_cfg (
	input wire logic pclk, // bus clock, 25 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output logic step5_enable, // step 5 in sequence
	output logic [1:0] step5_gain, // step 5 effective gain code
	output logic [3:0] step5_neg, // step 5 negative route, one-hot
	output logic [3:0] step5_pos, // step 5 positive code
	output logic step6_enable, // step 6 in sequence
	output logic [1:0] step6_gain, // step 6 effective gain code
	output logic [3:0] step6_neg, // step 6 negative route, one-hot
	output logic [3:0] step6_pos // step 6 positive code
);
	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	function automatic logic [1:0] dec(input logic [11:0] a);
		dec = 2'h0;
		if (a == `ASC_STEP5_ADDR) begin
			dec = 2'h1;
		end else if (a == `ASC_STEP6_ADDR) begin
			dec = 2'h2;
		end
	endfunction

	logic [1:0] hit;
	logic acc;
	assign hit = dec(paddr);
	assign acc = psel && penable;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	logic [15:0] r5;
	logic [15:0] r6;

	asc_step_reg #(.RST_VAL(`ASC_STEP5_RST)) u_r5 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(acc && pwrite && hit[0]),
		.wr_data(pwdata[15:0]),
		.q(r5)
	);

	asc_step_reg #(.RST_VAL(`ASC_STEP6_RST)) u_r6 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(acc && pwrite && hit[1]),
		.wr_data(pwdata[15:0]),
		.q(r6)
	);

	// --------------------------------------------------------------
	// decode to sequencer controls
	// --------------------------------------------------------------
	logic d5_en;
	logic d6_en;
	asc_pkg::asc_gain_t d5_g;
	asc_pkg::asc_gain_t d6_g;
	asc_pkg::asc_neg_t d5_n;
	asc_pkg::asc_neg_t d6_n;
	logic [3:0] d5_p;
	logic [3:0] d6_p;

	asc_step_decode u_d5 (
		.cfg(r5),
		.enable(d5_en),
		.gain(d5_g),
		.neg_sel(d5_n),
		.pos_sel(d5_p),
		.src_kind()
	);

	asc_step_decode u_d6 (
		.cfg(r6),
		.enable(d6_en),
		.gain(d6_g),
		.neg_sel(d6_n),
		.pos_sel(d6_p),
		.src_kind()
	);

	// --------------------------------------------------------------
	// bus answer and registered outputs
	// --------------------------------------------------------------
	logic [31:0] prdata_ff, nxt_prdata;
	logic pslverr_ff, nxt_pslverr;
	logic pready_ff, nxt_pready;
	logic [13:0] out_ff, nxt_out;
	logic [13:0] out6_ff, nxt_out6;

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		// answer in the setup cycle so access completes with no wait
		nxt_pready = psel && !penable;
		if (psel && !penable) begin
			unique case (hit)
				2'h1: nxt_prdata = {16'h0000, r5};
				2'h2: nxt_prdata = {16'h0000, r6};
				default: nxt_pslverr = 1'b1;
			endcase
			if (pwrite) begin
				nxt_prdata = 32'h0000_0000;
			end
		end
		nxt_out = {d5_en, d5_g, d5_n, d5_p, 3'h0};
		nxt_out6 = {d6_en, d6_g, d6_n, d6_p, 3'h0};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
			pready_ff <= 1'b0;
			// neg route one-hot ground, pos code as the register reset
			out_ff <= 14'h00a8;
			out6_ff <= 14'h00b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			pready_ff <= nxt_pready;
			out_ff <= nxt_out;
			out6_ff <= nxt_out6;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign step5_enable = out_ff[13];
	assign step5_gain = out_ff[12:11];
	assign step5_neg = out_ff[10:7];
	assign step5_pos = out_ff[6:3];
	assign step6_enable = out6_ff[13];
	assign step6_gain = out6_ff[12:11];
	assign step6_neg = out6_ff[10:7];
	assign step6_pos = out6_ff[6:3];
endmodule // asc_step_cfg

//--- sim/asc_step_cfg_properties.sv
// concurrent checks for the step configuration bank
`timescale 1ns/1ns
`include "asc_map.svh"
// ----------
// checker
// ----------
module asc_step_cfg_properties (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic step5_enable, // enable
	input wire logic [1:0] step5_gain, // gain
	input wire logic [3:0] step5_neg, // negative route
	input wire logic [3:0] step5_pos // positive code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire hit = paddr == `ASC_STEP5_ADDR || paddr == `ASC_STEP6_ADDR;
	sequence s_acc;
		psel && penable;
	endsequence
	// outputs show a write two edges after the access edge
	sequence s_wr5;
		s_acc ##0 pwrite && paddr == `ASC_STEP5_ADDR;
	endsequence
	a_rsv_reads_zero: assert property (pready |-> !prdata[12:5])
		else $error("reserved bits not zero");
	a_wr_sets_enable: assert property (s_wr5 |-> ##2
		step5_enable == $past(pwdata[15], 2)) else $error("enable");
	a_gain_decode: assert property (s_wr5 |-> ##2 step5_gain ==
		($past(pwdata[14], 2) ? 2'h2 : {1'b0, $past(pwdata[13], 2)}))
		else $error("gain decode");
	a_ext_neg_route: assert property (s_wr5 ##0 !pwdata[3] |-> ##2
		step5_neg == ($past(pwdata[4], 2) ? 4'h2 : 4'h1))
		else $error("negative route");
	a_pos_passes: assert property (s_wr5 |-> ##2
		step5_pos == $past(pwdata[3:0], 2)) else $error("positive code");
	a_int_auto_neg: assert property (step5_pos[3] |->
		step5_neg == 4'h4) else $error("no auto negative");
	a_unmapped_err: assert property (s_acc ##0 !hit |->
		pready && pslverr && !prdata) else $error("unmapped answer");
	a_mapped_ok: assert property (s_acc ##0 hit |->
		pready && !pslverr) else $error("mapped answer");
endmodule // asc_step_cfg_properties
bind asc_step_cfg asc_step_cfg_properties u_props (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .step5_enable, .step5_gain, .step5_neg, .step5_pos);

//--- sim/asc_step_cfg_test.sv
// self-checking bench for the step configuration bank
`timescale 1ns/1ns
`include "asc_map.svh"
// ----------
// bench
// ----------
module asc_step_cfg_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, e5, e6, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [1:0] g5, g6;
	logic [3:0] n5, p5, n6, p6;
	logic [15:0] d, v5, v6;
	int miscompares = 0, checks = 0;
	always #20 pclk = ~pclk;
	asc_step_cfg dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .step5_enable(e5),
		.step5_gain(g5), .step5_neg(n5), .step5_pos(p5),
		.step6_enable(e6), .step6_gain(g6), .step6_neg(n6),
		.step6_pos(p6));
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		chk(pready, 32'h1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// expected steering of one configuration word
	function automatic logic [10:0] dec(input logic [15:0] v);
		return {v[15], v[14] ? 2'h2 : v[14:13],
			v[3] ? 4'h4 : v[4] ? 4'h2 : 4'h1, v[3:0]};
	endfunction
	task automatic chk_out;
		repeat (2) @(posedge pclk);
		chk({e5, g5, n5, p5}, dec(v5));
		chk({e6, g6, n6, p6}, dec(v6));
	endtask
	initial begin
		#100000;
		miscompares++;
		end_sim;
	end
	initial begin
		v5 = 16'h0005;
		v6 = 16'h0006;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `ASC_STEP5_ADDR, 32'h0);
		chk(r, 32'h5);
		xfer(1'b0, `ASC_STEP6_ADDR, 32'h0);
		chk(r, 32'h6);
		chk_out;
		for (int i = 0; i < 32; i++) begin
			d = {i[0], i[2:1], 8'hff, i[2], i[3:0]};
			if (i[4])
				v6 = d;
			else
				v5 = d;
			xfer(1'b1, i[4] ? `ASC_STEP6_ADDR : `ASC_STEP5_ADDR,
				{16'hffff, d});
			chk_out;
			xfer(1'b0, i[4] ? `ASC_STEP6_ADDR : `ASC_STEP5_ADDR, 32'h0);
			chk(r, {16'h0, d & 16'he01f});
		end
		// byte address equal to the index must miss
		xfer(1'b1, 12'h095, 32'hffff);
		chk(err, 32'h1);
		xfer(1'b0, 12'h095, 32'h0);
		chk(err, 32'h1);
		chk(r, 32'h0);
		chk_out;
		end_sim;
	end
endmodule // asc_step_cfg_test
